//--- rtl/ofs_ctrl.sv
// Behaviour
// RULE_01: protection active in normal and fail mode
// RULE_02: shut output after fault deglitch delay
// RULE_03: listed fault causes use fast turn-off
// RULE_04: fast turn-off bypasses edge shaping
// RULE_05: fast turn-off held during undervoltage
// RULE_06: normal mode flags quick and channel status
// RULE_07: software restarts by rewriting channel on-bit
// RULE_08: fail mode auto-restarts after recoverable faults
// RULE_09: fail mode latches off until wake/mode change
// RULE_10: every channel protected independently
`timescale 1ns/10ps
`include "ofs_defines.svh"

module ofs_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ofs_pkg::ofs_fault_t [4:0] ch_fault_in,
  input wire logic fail_mode_in,
  input wire logic wake_in,
  input wire logic [4:0] ch_cmd_in,
  output logic [4:0] ch_en,
  output logic [4:0] fast_turn_off,
  output logic irq
);
  import ofs_pkg::*;

  localparam int NCH = `OFS_NCH;

  // pin synchronisers
  ofs_fault_t [4:0] flt_s1_ff;
  ofs_fault_t [4:0] flt_s2_ff;
  logic [6:0] pin_s1_ff;
  logic [6:0] pin_s2_ff;
  logic fail_d_ff;
  logic wake_d_ff;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flt_s1_ff <= '0;
      flt_s2_ff <= '0;
      pin_s1_ff <= 7'h00;
      pin_s2_ff <= 7'h00;
      fail_d_ff <= 1'b0;
      wake_d_ff <= 1'b0;
    end else begin
      flt_s1_ff <= ch_fault_in;
      flt_s2_ff <= flt_s1_ff;
      pin_s1_ff <= {wake_in, fail_mode_in, ch_cmd_in};
      pin_s2_ff <= pin_s1_ff;
      fail_d_ff <= pin_s2_ff[5];
      wake_d_ff <= pin_s2_ff[6];
    end
  end

  logic fail_s;
  logic mode_chg;
  logic wake_rise;
  logic [4:0] cmd_s;
  assign fail_s = pin_s2_ff[5];
  assign cmd_s = pin_s2_ff[4:0];
  assign mode_chg = fail_s != fail_d_ff;
  assign wake_rise = pin_s2_ff[6] && !wake_d_ff;

  // apb slave, one wait state
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic acc_first;
  logic wr_done;
  logic [5:0] idx;
  logic [31:0] rd_val;
  logic rd_ok;

  assign acc_first = psel && penable && !pready_ff;
  assign wr_done = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign idx = paddr[7:2];

  // channel state
  ofs_ch_state_t st_ff [NCH];
  ofs_ch_state_t nxt_st [NCH];
  logic [4:0] on_ff, nxt_on;
  logic [4:0] on_wr;
  logic [4:0] fto_ff, nxt_fto;
  logic [4:0] ch_en_ff, nxt_ch_en;
  logic [4:0] trip;
  logic [4:0] fault_act;
  logic [4:0] go_on;
  logic [4:0] off_req;
  logic [8:0] chs_ff [NCH];
  logic [8:0] nxt_chs [NCH];
  logic [8:0] chs_clr [NCH];
  logic [4:0] quick;
  logic [4:0] ist_ff, nxt_ist;
  logic [4:0] mask_ff, nxt_mask;
  logic [4:0] ist_clr;
  logic irq_ff, nxt_irq;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign fault_act[g] = |flt_s2_ff[g];
      assign quick[g] = |chs_ff[g];
      ofs_deglitch u_dgl (
        .mclk(mclk),
        .nrst(nrst),
        .fault_act(fault_act[g]),
        .clr(go_on[g]),
        .trip(trip[g])
      );
    end
  endgenerate

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = paddr[1:0] == 2'b00;
    if (idx >= `OFS_IDX_CH_CTRL && idx < `OFS_IDX_CH_CTRL + 6'(NCH)) begin
      rd_val = {31'h0, on_ff[3'(idx - `OFS_IDX_CH_CTRL)]};
    end else if (idx >= `OFS_IDX_CH_STAT && idx < `OFS_IDX_CH_STAT + 6'(NCH)) begin
      rd_val = {23'h0, chs_ff[3'(idx - `OFS_IDX_CH_STAT)]};
    end else begin
      case (paddr)
        `OFS_REG_OUT_CTRL: rd_val = {27'h0, on_ff};
        `OFS_REG_QUICK_STAT: rd_val = {27'h0, quick};
        `OFS_REG_INT_STAT: rd_val = {27'h0, ist_ff};
        `OFS_REG_INT_MASK: rd_val = {27'h0, mask_ff};
        `OFS_REG_MODE_STAT: rd_val = {19'h0, fto_ff, 7'h0, fail_s};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    nxt_pready = acc_first;
    nxt_pslverr = acc_first && !rd_ok;
    nxt_prdata = prdata_ff;
    if (acc_first) begin
      nxt_prdata = (pwrite || !rd_ok) ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // register writes and sticky status
  always_comb begin
    nxt_on = on_ff;
    on_wr = 5'h00;
    nxt_mask = mask_ff;
    ist_clr = 5'h00;
    for (int i = 0; i < NCH; i++) begin
      chs_clr[i] = 9'h000;
    end
    if (wr_done) begin
      if (idx >= `OFS_IDX_CH_CTRL && idx < `OFS_IDX_CH_CTRL + 6'(NCH)) begin
        nxt_on[3'(idx - `OFS_IDX_CH_CTRL)] = pwdata[`OFS_CH_CTRL_ON_BIT];
        on_wr[3'(idx - `OFS_IDX_CH_CTRL)] = pwdata[`OFS_CH_CTRL_ON_BIT]; // RULE_07
      end else if (idx >= `OFS_IDX_CH_STAT && idx < `OFS_IDX_CH_STAT + 6'(NCH)) begin
        chs_clr[3'(idx - `OFS_IDX_CH_STAT)] = pwdata[8:0];
      end else begin
        case (paddr)
          `OFS_REG_OUT_CTRL: begin
            nxt_on = pwdata[4:0];
            on_wr = pwdata[4:0]; // RULE_07
          end
          `OFS_REG_INT_STAT: ist_clr = pwdata[4:0];
          `OFS_REG_INT_MASK: nxt_mask = pwdata[4:0];
          default: nxt_on = on_ff;
        endcase
      end
    end
    // hardware set beats a same-cycle clear
    nxt_ist = (ist_ff & ~ist_clr) | trip;
    for (int i = 0; i < NCH; i++) begin
      nxt_chs[i] = (chs_ff[i] & ~chs_clr[i]) | (trip[i] ? 9'(flt_s2_ff[i]) : 9'h000); // RULE_06
    end
    nxt_irq = |(nxt_ist & nxt_mask);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      on_ff <= `OFS_RST_ON;
      mask_ff <= `OFS_RST_MASK;
      ist_ff <= 5'h00;
      irq_ff <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        chs_ff[i] <= `OFS_RST_STAT;
      end
    end else begin
      on_ff <= nxt_on;
      mask_ff <= nxt_mask;
      ist_ff <= nxt_ist;
      irq_ff <= nxt_irq;
      for (int i = 0; i < NCH; i++) begin
        chs_ff[i] <= nxt_chs[i];
      end
    end
  end

  // per-channel shutdown and restart, no shared state between channels
  always_comb begin
    nxt_fto = fto_ff;
    go_on = 5'h00;
    off_req = 5'h00;
    for (int i = 0; i < NCH; i++) begin
      nxt_st[i] = st_ff[i]; // RULE_10
      case (st_ff[i])
        ST_OFF: begin
          if (!mode_chg && !fault_act[i] && (fail_s ? cmd_s[i] : on_ff[i])) begin
            go_on[i] = 1'b1;
          end
        end
        ST_ON: begin
          if (trip[i]) begin
            if (!fail_s) begin
              nxt_st[i] = ST_FAULT; // RULE_01
            end else if (|(9'(flt_s2_ff[i]) & `OFS_LATCH_CAUSES)) begin
              nxt_st[i] = ST_LATCH; // RULE_09
            end else begin
              nxt_st[i] = ST_RETRY; // RULE_08
            end
            if (|(9'(flt_s2_ff[i]) & `OFS_FTO_CAUSES)) begin
              nxt_fto[i] = 1'b1; // RULE_03
            end
          end else if (mode_chg || !(fail_s ? cmd_s[i] : on_ff[i])) begin
            off_req[i] = 1'b1;
            nxt_st[i] = ST_OFF;
          end
        end
        ST_FAULT: begin
          if (mode_chg) begin
            nxt_st[i] = ST_OFF;
          end else if (on_wr[i] && !flt_s2_ff[i].undervoltage_fault) begin
            go_on[i] = 1'b1; // RULE_07
          end
        end
        ST_RETRY: begin
          if (mode_chg || !cmd_s[i]) begin
            nxt_st[i] = ST_OFF;
          end else if (!fault_act[i]) begin
            go_on[i] = 1'b1; // RULE_08
          end
        end
        ST_LATCH: begin
          if (mode_chg || wake_rise) begin
            nxt_st[i] = ST_OFF; // RULE_09
          end
        end
        default: nxt_st[i] = ST_OFF;
      endcase
      // no restart is possible while undervoltage stands, so the latch holds
      if (go_on[i]) begin
        nxt_st[i] = ST_ON;
        nxt_fto[i] = 1'b0; // RULE_05
      end
      nxt_ch_en[i] = nxt_st[i] == ST_ON;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fto_ff <= 5'h00;
      ch_en_ff <= 5'h00;
      for (int i = 0; i < NCH; i++) begin
        st_ff[i] <= ST_OFF;
      end
    end else begin
      fto_ff <= nxt_fto;
      ch_en_ff <= nxt_ch_en;
      for (int i = 0; i < NCH; i++) begin
        st_ff[i] <= nxt_st[i];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ch_en = ch_en_ff;
  // drivers take this as the shaping bypass, hard slew off
  assign fast_turn_off = fto_ff; // RULE_04
  assign irq = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_trip_turns_off: assert property (trip[0] && st_ff[0] == ST_ON |=> !ch_en_ff[0]) // RULE_02
    else $error("channel 0 still on after fault trip");
  a_dgl_min_wait: assert property (trip[0] |-> $past(fault_act[0], `OFS_DGL_CYC - 1)) // RULE_02
    else $error("trip fired before deglitch delay");
  a_fail_protect: assert property (fail_s && trip[1] && st_ff[1] == ST_ON |=> st_ff[1] != ST_ON) // RULE_01
    else $error("fail mode fault left channel on");
  a_fto_on_cause: assert property (trip[0] && st_ff[0] == ST_ON // RULE_03
      && (9'(flt_s2_ff[0]) & `OFS_FTO_CAUSES) != 9'h000 |=> fast_turn_off[0])
    else $error("fast turn-off missing after fault");
  a_fto_no_drive: assert property ((fast_turn_off & ch_en) == 5'h00) // RULE_04
    else $error("fast turn-off with output enabled");
  a_uv_holds_fto: assert property (fast_turn_off[0] && flt_s2_ff[0].undervoltage_fault // RULE_05
      |=> fast_turn_off[0])
    else $error("fast turn-off dropped under undervoltage");
  a_status_flag: assert property (trip[0] && !fail_s |=> quick[0] && ist_ff[0]) // RULE_06
    else $error("fault not flagged in status");
  a_auto_retry: assert property (trip[0] && fail_s && st_ff[0] == ST_ON // RULE_08
      && (9'(flt_s2_ff[0]) & `OFS_LATCH_CAUSES) == 9'h000 |=> st_ff[0] == ST_RETRY)
    else $error("recoverable fault did not enter auto-restart");
  a_latch_holds: assert property (st_ff[0] == ST_LATCH && !mode_chg && !wake_rise // RULE_09
      |=> st_ff[0] == ST_LATCH)
    else $error("latched-off channel restarted");
  a_ch_indep: assert property (trip[0] && !trip[1] && st_ff[1] == ST_ON && !off_req[1] // RULE_10
      |=> ch_en[1])
    else $error("fault on channel 0 disturbed channel 1");

  c_norm_restart: cover property (st_ff[0] == ST_FAULT ##[1:300] st_ff[0] == ST_ON);
  c_fail_latch: cover property (st_ff[2] == ST_LATCH ##[1:300] wake_rise);
  c_fail_retry: cover property (st_ff[3] == ST_RETRY ##[1:300] st_ff[3] == ST_ON);
  c_irq: cover property ($rose(irq));

endmodule : ofs_ctrl

//--- rtl/ofs_deglitch.sv
`timescale 1ns/10ps
`include "ofs_defines.svh"

module ofs_deglitch (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fault_act,
  input wire logic clr,
  output logic trip
);
  import ofs_pkg::*;

  localparam logic [7:0] DGL_CYC = 8'(`OFS_DGL_CYC);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // saturates after the trip so a steady fault fires only once
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!fault_act || clr) begin
      nxt_cnt = 8'h00;
    end else if (cnt_ff != DGL_CYC) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign trip = fault_act && !clr && (cnt_ff == DGL_CYC - 8'h01); // RULE_02

endmodule : ofs_deglitch

//--- shared/ofs_defines.svh
`ifndef OFS_DEFINES_SVH
`define OFS_DEFINES_SVH

`define OFS_NCH 5
`define OFS_CLK_NS 20
// shutdown deglitch window, typical point of the allowed span
`define OFS_DGL_MIN_NS 500
`define OFS_DGL_MAX_NS 4500
`define OFS_DGL_NS 2500
`define OFS_DGL_CYC ((`OFS_DGL_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)

// register byte offsets
`define OFS_REG_OUT_CTRL 8'h00
`define OFS_REG_QUICK_STAT 8'h04
`define OFS_REG_INT_STAT 8'h08
`define OFS_REG_INT_MASK 8'h0c
`define OFS_REG_MODE_STAT 8'h10
// word indexes of the per-channel banks, stride one word
`define OFS_IDX_CH_CTRL 6'h08
`define OFS_IDX_CH_STAT 6'h10

// field positions
`define OFS_CH_CTRL_ON_BIT 0
`define OFS_MODE_FAIL_BIT 0
`define OFS_MODE_FTO_LSB 8

// reset values
`define OFS_RST_ON 5'h00
`define OFS_RST_MASK 5'h00
`define OFS_RST_STAT 9'h000

// fault cause classes, bit 0 = first high window ... bit 8 = severe short
`define OFS_FTO_CAUSES 9'h0ff
`define OFS_LATCH_CAUSES 9'h111

`endif

//--- shared/ofs_pkg.sv
package ofs_pkg;

  typedef struct packed {
    logic severe_short_circuit;
    logic open_load_in_off_state;
    logic charge_pump_fail;
    logic undervoltage_fault;
    logic overtemp_shutdown;
    logic low_overcurrent_threshold;
    logic high_current_window_third;
    logic high_current_window_second;
    logic high_current_window_first;
  } ofs_fault_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON,
    ST_FAULT,
    ST_RETRY,
    ST_LATCH
  } ofs_ch_state_t;

endpackage : ofs_pkg

//--- sim/ofs_load_model.sv
`timescale 1ns/10ps
module ofs_load_model
  import ofs_pkg::*;
(
  input wire logic mclk,
  input wire ofs_pkg::ofs_fault_t [4:0] inj,
  output ofs_pkg::ofs_fault_t [4:0] ch_fault_in
);
  // stage reports injected faults one edge late, like a real comparator path
  always_ff @(posedge mclk) begin
    ch_fault_in <= inj;
  end
endmodule : ofs_load_model

//--- sim/test_output_fault_shutdown_ctrl.sv
`timescale 1ns/10ps
module test_output_fault_shutdown_ctrl;
  import ofs_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ofs_fault_t [4:0] inj = '0;
  ofs_fault_t [4:0] ch_fault_in;
  logic fail_mode_in = 1'b0;
  logic wake_in = 1'b0;
  logic [4:0] ch_cmd_in = 5'h00;
  logic [4:0] ch_en;
  logic [4:0] fast_turn_off;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;
  int ch;
  logic [4:0] others;

  always #10 mclk = ~mclk;

  ofs_ctrl dut (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_fault_in(ch_fault_in), .fail_mode_in(fail_mode_in), .wake_in(wake_in),
    .ch_cmd_in(ch_cmd_in), .ch_en(ch_en), .fast_turn_off(fast_turn_off), .irq(irq));
  ofs_load_model stage (.mclk(mclk), .inj(inj), .ch_fault_in(ch_fault_in));

  function automatic logic uses_fto(input int k);
    return k < 8;
  endfunction : uses_fto

  function automatic logic latches(input int k);
    return k == 0 || k == 4 || k == 8;
  endfunction : latches

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pin held until the channel drops; trip must land well past the deglitch floor
  task automatic trip(input int c, input int k);
    int n;
    n = 0;
    @(posedge mclk);
    inj[c][k] <= 1'b1;
    repeat (110) @(posedge mclk);
    chk(ch_en[c], 1'b1);
    while (ch_en[c] === 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(n > 5 && n < 40, 1'b1);
    @(posedge mclk);
    others = 5'h1f & ~(5'h01 << c);
    chk(ch_en & others, others);
  endtask : trip

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    #1000000;
    errors++;
    close_out();
  end

  initial begin
    void'($urandom(34));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk({ch_en, fast_turn_off, irq}, 32'h0);
    foreach (rd[i]) begin
      if (i < 4) begin
        apb(1'b0, 8'(i * 4 + (i > 1 ? 4 : 0)), 32'h0);
        chk(rd, 32'h0);
      end
    end
    apb(1'b0, 8'h80, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h02, 32'h1f);
    chk(err, 1'b1);
    $display("test registers done");
    apb(1'b1, 8'h0c, 32'h1f);
    apb(1'b1, 8'h00, 32'h1f);
    repeat (2) @(posedge mclk);
    chk(ch_en, 5'h1f);
    ch = $urandom_range(4, 0);
    inj[ch][3] <= 1'b1;
    repeat (60) @(posedge mclk);
    inj[ch][3] <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(ch_en, 5'h1f);
    for (int k = 0; k < 9; k++) begin
      ch = $urandom_range(4, 0);
      trip(ch, k);
      chk(fast_turn_off, 32'(uses_fto(k)) << ch);
      chk(irq, 1'b1);
      apb(1'b0, 8'(8'h40 + 4 * ch), 32'h0);
      chk(rd[8:0], 9'h001 << k);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[4:0], 5'h01 << ch);
      // rewrite taken with the fault still standing; only undervoltage holds it off
      apb(1'b1, 8'(8'h20 + 4 * ch), 32'h1);
      repeat (2) @(posedge mclk);
      chk(ch_en[ch], k != 5);
      chk(fast_turn_off[ch], k == 5);
      apb(1'b1, 8'h0c, 32'h0);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      apb(1'b1, 8'h0c, 32'h1f);
      inj[ch][k] <= 1'b0;
      apb(1'b1, 8'(8'h40 + 4 * ch), 32'h1ff);
      apb(1'b1, 8'h08, 32'h1f);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      if (k % 2 == 1) begin
        apb(1'b1, 8'h00, 32'h1f);
      end else begin
        apb(1'b1, 8'(8'h20 + 4 * ch), 32'h1);
      end
      repeat (2) @(posedge mclk);
      chk(ch_en, 5'h1f);
      chk(fast_turn_off, 5'h00);
      $display("test normal cause %0d done", k);
    end
    ch_cmd_in <= 5'h1f;
    fail_mode_in <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(ch_en, 5'h1f);
    for (int k = 0; k < 9; k++) begin
      ch = $urandom_range(4, 0);
      trip(ch, k);
      inj[ch][k] <= 1'b0;
      repeat (10) @(posedge mclk);
      chk(ch_en[ch], !latches(k));
      if (latches(k)) begin
        wake_in <= 1'b1;
        repeat (3) @(posedge mclk);
        wake_in <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(ch_en[ch], 1'b1);
      end
      $display("test fail cause %0d done", k);
    end
    ch = $urandom_range(4, 0);
    trip(ch, 4);
    inj[ch][4] <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(ch_en[ch], 1'b0);
    fail_mode_in <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(ch_en, 5'h1f);
    $display("test mode change done");
    close_out();
  end
endmodule : test_output_fault_shutdown_ctrl
